/* File: common/cplvp_pkg.sv */
// Contract
// - program memory has three protection blocks; boot block is 512 bytes at zero.
// - block 0 spans 000200h-0007FFh, block 1 spans 000800h-000FFFh.
// - each block has external-access, table-write and cross-read inhibits.
// - protection bits live in six config bytes 300008h through 30000Dh.
// - external-access inhibit only affects programmer accesses, not execution.
// - table writes to a block with write inhibit zero are rejected.
// - with cross-read inhibit zero, reads from inside the block still succeed.
// - with cross-read inhibit zero, reads from outside the block return zero.
// - protection bits only go one to zero; writing one over zero keeps zero.
// - only programmer-started chip or block erase restores bits to one.
// - eeprom read-protect blocks programmer access; write-protect blocks its writes.
// - cpu accesses eeprom normally regardless of protection bits.
// - config write-protect is read-only in execution; programmer alone changes it.
// - eight user ID bytes ending 200007h, readable and writable by both sides.
// - user ID bytes stay readable under code protection.
// - debug bit zero enables debugger and reserves its resources.
// - with low-voltage programming on, entry pin is withheld from general I/O.
// - low-voltage programming is enabled in erased configuration.
// - high-voltage entry via master clear is always accepted.
// - low-voltage enable changes only in high-voltage programming.
// - protected memory needs block erase; unprotected may also be row erased.
package cplvp_pkg;
    localparam int ADDR_W = 22;
    localparam logic [21:0] BOOT_END    = 22'h00_01FF;
    localparam logic [21:0] BLK0_END    = 22'h00_07FF;
    localparam logic [21:0] BLK1_END    = 22'h00_0FFF;
    localparam logic [21:0] ID_BASE     = 22'h20_0000;
    localparam logic [21:0] ID_LAST     = 22'h20_0007;
    localparam logic [21:0] CFG_DBG     = 22'h30_0006;
    localparam logic [21:0] CFG_CP_L    = 22'h30_0008;
    localparam logic [21:0] CFG_CP_H    = 22'h30_0009;
    localparam logic [21:0] CFG_WR_L    = 22'h30_000A;
    localparam logic [21:0] CFG_WR_H    = 22'h30_000B;
    localparam logic [21:0] CFG_RD_L    = 22'h30_000C;
    localparam logic [21:0] CFG_RD_H    = 22'h30_000D;
    // implemented-bit masks for each config byte
    localparam logic [7:0] MSK_LOW      = 8'h03;
    localparam logic [7:0] MSK_CP_H     = 8'hC0;
    localparam logic [7:0] MSK_WR_H     = 8'hE0;
    localparam logic [7:0] MSK_RD_H     = 8'h40;
    localparam logic [7:0] MSK_DBG      = 8'h84;
    localparam int BIT_EEPROT  = 7;
    localparam int BIT_BOOT    = 6;
    localparam int BIT_CFGWP   = 5;
    localparam int BIT_DEBUG   = 7;
    localparam int BIT_LVP     = 2;
    localparam int ID_NUM      = 8;
    localparam logic [7:0] ERASED       = 8'hFF;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    typedef enum logic [1:0] {
        CPLVP_BLK_BOOT, CPLVP_BLK_0, CPLVP_BLK_1, CPLVP_BLK_NONE
    } cplvp_blk_t;

    typedef enum logic [1:0] {
        CPLVP_ER_NONE, CPLVP_ER_CHIP, CPLVP_ER_BLOCK, CPLVP_ER_ROW
    } cplvp_erase_t;

    // one table access, from cpu or programmer
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } cplvp_req_t;

    typedef struct packed {
        logic       valid;
        logic       allow;
        logic [7:0] rdata;
    } cplvp_rsp_t;
endpackage : cplvp_pkg

/* File: hdl/cplvp_protect.sv */
`timescale 1ns/1ps
module cplvp_protect
    import cplvp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire cplvp_req_t        cpuReq,
    input  wire logic [ADDR_W-1:0] cpuPc,
    input  wire logic              cpuEeRd,
    input  wire logic              cpuEeWr,
    input  wire cplvp_req_t        pgmReq,
    input  wire logic              pgmEeRd,
    input  wire logic              pgmEeWr,
    input  wire cplvp_erase_t      pgmErase,
    input  wire cplvp_blk_t        pgmEraseBlk,
    input  wire logic              masterClearHv,
    input  wire logic              programEntryPin,
    input  wire logic [7:0]        flashRdata,
    output logic                   progModeHv,
    output logic                   progModeLv,
    output cplvp_rsp_t             cpuRsp,
    output cplvp_rsp_t             pgmRsp,
    output logic                   flashWrEn,
    output logic                   flashWrPgm,
    output logic                   eeAllow,
    output logic                   eraseGo,
    output logic                   eraseRefused,
    output logic                   debugEnable,
    output logic                   entryPinIsGpio
);
    // ------------------------------------------------------------
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic [2:0] hvSync_reg, hvSync_next, pgmSync_reg, pgmSync_next;
    logic       hvLvl_reg, hvLvl_next, pinLvl_reg, pinLvl_next;
    always_comb begin
        hvSync_next  = {hvSync_reg[1:0], masterClearHv};
        pgmSync_next = {pgmSync_reg[1:0], programEntryPin};
        hvLvl_next   = (hvSync_reg[1] == hvSync_reg[2]) ? hvSync_reg[2]
                                                        : hvLvl_reg;
        pinLvl_next  = (pgmSync_reg[1] == pgmSync_reg[2]) ? pgmSync_reg[2]
                                                          : pinLvl_reg;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hvSync_reg  <= 3'h0;
            pgmSync_reg <= 3'h0;
            hvLvl_reg   <= 1'b0;
            pinLvl_reg  <= 1'b0;
        end else begin
            hvSync_reg  <= hvSync_next;
            pgmSync_reg <= pgmSync_next;
            hvLvl_reg   <= hvLvl_next;
            pinLvl_reg  <= pinLvl_next;
        end
    end

    // ------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------
    // reset models the nonvolatile erased state; real storage would
    // reload these from flash instead
    logic [7:0] cpL_reg, cpH_reg, wrL_reg, wrH_reg, rdL_reg, rdH_reg;
    logic [7:0] dbg_reg;
    logic [7:0] cpL_next, cpH_next, wrL_next, wrH_next, rdL_next, rdH_next;
    logic [7:0] dbg_next;
    logic [7:0] ids_reg [ID_NUM];
    logic [7:0] ids_next [ID_NUM];

    logic inPgm;
    assign inPgm = progModeHv | progModeLv;

    function automatic cplvp_blk_t blkOf(input logic [ADDR_W-1:0] a);
        if (a <= BOOT_END)      blkOf = CPLVP_BLK_BOOT;
        else if (a <= BLK0_END) blkOf = CPLVP_BLK_0;
        else if (a <= BLK1_END) blkOf = CPLVP_BLK_1;
        else                    blkOf = CPLVP_BLK_NONE;
    endfunction : blkOf

    // per-block bit pick: 1 means unprotected, as erased
    function automatic logic pick(input cplvp_blk_t b, input logic [7:0] lo,
                                  input logic [7:0] hi);
        case (b)
            CPLVP_BLK_BOOT: pick = hi[BIT_BOOT];
            CPLVP_BLK_0:    pick = lo[0];
            CPLVP_BLK_1:    pick = lo[1];
            default:        pick = 1'b1;
        endcase
    endfunction : pick

    function automatic logic isCfg(input logic [ADDR_W-1:0] a);
        isCfg = (a == CFG_DBG) || ((a >= CFG_CP_L) && (a <= CFG_RD_H));
    endfunction : isCfg

    cplvp_blk_t cpuBlk, pcBlk, pgmBlk;
    logic cpuIsId, pgmIsId, cfgWp;
    assign cpuBlk  = blkOf(cpuReq.addr);
    assign pcBlk   = blkOf(cpuPc);
    assign pgmBlk  = blkOf(pgmReq.addr);
    assign cpuIsId = (cpuReq.addr >= ID_BASE) && (cpuReq.addr <= ID_LAST);
    assign pgmIsId = (pgmReq.addr >= ID_BASE) && (pgmReq.addr <= ID_LAST);
    assign cfgWp   = ~wrH_reg[BIT_CFGWP];

    // erase: programmer only; row erase refused on protected block
    logic erOk;
    always_comb begin
        erOk = 1'b0;
        if (inPgm) begin
            case (pgmErase)
                CPLVP_ER_CHIP:  erOk = 1'b1;
                CPLVP_ER_BLOCK: erOk = 1'b1;
                CPLVP_ER_ROW:   erOk = pick(pgmBlk, cpL_reg, cpH_reg);
                default:        erOk = 1'b0;
            endcase
        end
    end

    // a write may only clear bits: new = old & data
    function automatic logic [7:0] prog(input logic [7:0] old,
                                        input logic [7:0] d,
                                        input logic [7:0] m);
        prog = (old & d) | ~m;
    endfunction : prog

    logic cpuCfgWr, pgmCfgWr;
    assign cpuCfgWr = cpuReq.wr && !inPgm && isCfg(cpuReq.addr) && !cfgWp;
    assign pgmCfgWr = pgmReq.wr && inPgm && isCfg(pgmReq.addr);

    always_comb begin
        logic [ADDR_W-1:0] wa;
        logic [7:0]        wd;
        logic              we;
        we = pgmCfgWr | cpuCfgWr;
        wa = pgmCfgWr ? pgmReq.addr  : cpuReq.addr;
        wd = pgmCfgWr ? pgmReq.wdata : cpuReq.wdata;
        cpL_next = cpL_reg;
        cpH_next = cpH_reg;
        wrL_next = wrL_reg;
        wrH_next = wrH_reg;
        rdL_next = rdL_reg;
        rdH_next = rdH_reg;
        dbg_next = dbg_reg;
        ids_next = ids_reg;
        if (we) begin
            if (wa == CFG_CP_L)      cpL_next = prog(cpL_reg, wd, MSK_LOW);
            else if (wa == CFG_CP_H) cpH_next = prog(cpH_reg, wd, MSK_CP_H);
            else if (wa == CFG_WR_L) wrL_next = prog(wrL_reg, wd, MSK_LOW);
            else if (wa == CFG_WR_H) begin
                // code keeps the config write-protect bit as is
                if (!pgmCfgWr)
                    wd[BIT_CFGWP] = 1'b1;
                wrH_next = prog(wrH_reg, wd, MSK_WR_H);
            end
            else if (wa == CFG_RD_L) rdL_next = prog(rdL_reg, wd, MSK_LOW);
            else if (wa == CFG_RD_H) rdH_next = prog(rdH_reg, wd, MSK_RD_H);
            else if (wa == CFG_DBG) begin
                dbg_next = prog(dbg_reg, wd, MSK_DBG);
                // low-voltage enable is frozen outside hv mode
                if (!(pgmCfgWr && progModeHv))
                    dbg_next[BIT_LVP] = dbg_reg[BIT_LVP];
                else
                    dbg_next[BIT_LVP] = wd[BIT_LVP];
            end
        end
        if (erOk && pgmErase == CPLVP_ER_CHIP) begin
            cpL_next = ERASED;
            cpH_next = ERASED;
            wrL_next = ERASED;
            wrH_next = ERASED;
            rdL_next = ERASED;
            rdH_next = ERASED;
            dbg_next = ERASED;
        end else if (erOk && pgmErase == CPLVP_ER_BLOCK) begin
            case (pgmEraseBlk)
                CPLVP_BLK_BOOT: begin
                    cpH_next[BIT_BOOT] = 1'b1;
                    wrH_next[BIT_BOOT] = 1'b1;
                    rdH_next[BIT_BOOT] = 1'b1;
                end
                CPLVP_BLK_0, CPLVP_BLK_1: begin
                    cpL_next[pgmEraseBlk == CPLVP_BLK_1] = 1'b1;
                    wrL_next[pgmEraseBlk == CPLVP_BLK_1] = 1'b1;
                    rdL_next[pgmEraseBlk == CPLVP_BLK_1] = 1'b1;
                end
                default: ;
            endcase
        end
        // id bytes: cpu table writes and programmer writes
        for (int i = 0; i < ID_NUM; i++) begin
            if (pgmReq.wr && inPgm && pgmIsId && pgmReq.addr[2:0] == i[2:0])
                ids_next[i] = pgmReq.wdata;
            else if (cpuReq.wr && !inPgm && cpuIsId
                     && cpuReq.addr[2:0] == i[2:0])
                ids_next[i] = cpuReq.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cpL_reg <= ERASED;
            cpH_reg <= ERASED;
            wrL_reg <= ERASED;
            wrH_reg <= ERASED;
            rdL_reg <= ERASED;
            rdH_reg <= ERASED;
            dbg_reg <= ERASED;   // erased config: lvp on
            for (int i = 0; i < ID_NUM; i++)
                ids_reg[i] <= ERASED;
        end else begin
            cpL_reg <= cpL_next;
            cpH_reg <= cpH_next;
            wrL_reg <= wrL_next;
            wrH_reg <= wrH_next;
            rdL_reg <= rdL_next;
            rdH_reg <= rdH_next;
            dbg_reg <= dbg_next;
            ids_reg <= ids_next;
        end
    end

    // ------------------------------------------------------------
    // access decisions and registered outputs
    // ------------------------------------------------------------
    logic lvpOn;
    assign lvpOn = dbg_reg[BIT_LVP];

    function automatic logic [7:0] cfgRead(input logic [ADDR_W-1:0] a,
                                           input logic [7:0] c0, c1, c2,
                                           input logic [7:0] c3, c4, c5,
                                           input logic [7:0] c6);
        if (a == CFG_CP_L)      cfgRead = c0 & MSK_LOW;
        else if (a == CFG_CP_H) cfgRead = c1 & MSK_CP_H;
        else if (a == CFG_WR_L) cfgRead = c2 & MSK_LOW;
        else if (a == CFG_WR_H) cfgRead = c3 & MSK_WR_H;
        else if (a == CFG_RD_L) cfgRead = c4 & MSK_LOW;
        else if (a == CFG_RD_H) cfgRead = c5 & MSK_RD_H;
        else if (a == CFG_DBG)  cfgRead = c6 & MSK_DBG;
        else                    cfgRead = ZERO_BYTE;
    endfunction : cfgRead

    cplvp_rsp_t cpuRsp_next, pgmRsp_next;
    logic flashWrEn_next, flashWrPgm_next, eeAllow_next;
    logic hvMode_next, lvMode_next, eraseGo_next, eraseRef_next;
    always_comb begin
        logic cpuOk, pgmOk;
        // table write inhibit bit zero rejects the cpu write
        cpuOk = cpuReq.wr ? pick(cpuBlk, wrL_reg, wrH_reg) : 1'b1;
        // cross-read inhibit zero: only same-block code may read
        if (cpuReq.rd && cpuBlk != CPLVP_BLK_NONE
            && !pick(cpuBlk, rdL_reg, rdH_reg) && pcBlk != cpuBlk)
            cpuOk = 1'b0;
        // external inhibit only matters for programmer accesses
        pgmOk = pick(pgmBlk, cpL_reg, cpH_reg);
        if (pgmIsId)
            pgmOk = 1'b1;
        cpuRsp_next.valid = (cpuReq.rd | cpuReq.wr) & ~inPgm;
        cpuRsp_next.allow = cpuOk;
        if (cpuIsId)
            cpuRsp_next.rdata = ids_reg[cpuReq.addr[2:0]];
        else if (isCfg(cpuReq.addr))
            cpuRsp_next.rdata = cfgRead(cpuReq.addr, cpL_reg, cpH_reg,
                                        wrL_reg, wrH_reg, rdL_reg, rdH_reg,
                                        dbg_reg);
        else
            cpuRsp_next.rdata = (cpuOk && cpuBlk != CPLVP_BLK_NONE)
                                ? flashRdata : ZERO_BYTE;
        pgmRsp_next.valid = (pgmReq.rd | pgmReq.wr) & inPgm;
        pgmRsp_next.allow = pgmOk;
        if (pgmIsId)
            pgmRsp_next.rdata = ids_reg[pgmReq.addr[2:0]];
        else if (isCfg(pgmReq.addr))
            pgmRsp_next.rdata = cfgRead(pgmReq.addr, cpL_reg, cpH_reg,
                                        wrL_reg, wrH_reg, rdL_reg, rdH_reg,
                                        dbg_reg);
        else
            pgmRsp_next.rdata = (pgmOk && pgmBlk != CPLVP_BLK_NONE)
                                ? flashRdata : ZERO_BYTE;
        flashWrEn_next  = (cpuReq.wr && !inPgm && cpuOk
                           && cpuBlk != CPLVP_BLK_NONE)
                        | (pgmReq.wr && inPgm && pgmOk
                           && pgmBlk != CPLVP_BLK_NONE);
        flashWrPgm_next = pgmReq.wr && inPgm;
        // eeprom: cpu allowed outside programming mode, programmer gated
        if (inPgm)
            eeAllow_next = (pgmEeRd && cpH_reg[BIT_EEPROT])
                         | (pgmEeWr && cpH_reg[BIT_EEPROT]
                            && wrH_reg[BIT_EEPROT]);
        else
            eeAllow_next = cpuEeRd | cpuEeWr;
        hvMode_next   = hvLvl_reg;
        lvMode_next   = lvpOn && pinLvl_reg && !hvLvl_reg;
        eraseGo_next  = erOk;
        eraseRef_next = (pgmErase != CPLVP_ER_NONE) && !erOk;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cpuRsp         <= '0;
            pgmRsp         <= '0;
            flashWrEn      <= 1'b0;
            flashWrPgm     <= 1'b0;
            eeAllow        <= 1'b0;
            progModeHv     <= 1'b0;
            progModeLv     <= 1'b0;
            eraseGo        <= 1'b0;
            eraseRefused   <= 1'b0;
            debugEnable    <= 1'b0;
            entryPinIsGpio <= 1'b0;
        end else begin
            cpuRsp         <= cpuRsp_next;
            pgmRsp         <= pgmRsp_next;
            flashWrEn      <= flashWrEn_next;
            flashWrPgm     <= flashWrPgm_next;
            eeAllow        <= eeAllow_next;
            progModeHv     <= hvMode_next;
            progModeLv     <= lvMode_next;
            eraseGo        <= eraseGo_next;
            eraseRefused   <= eraseRef_next;
            debugEnable    <= ~dbg_reg[BIT_DEBUG];
            entryPinIsGpio <= ~lvpOn;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_cross_read_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        cpuReq.rd && !inPgm && cpuBlk == CPLVP_BLK_0 && !rdL_reg[0]
        && pcBlk != CPLVP_BLK_0 |=> cpuRsp.rdata == ZERO_BYTE)
        else $error("cross-block read returned data");
    a_same_blk_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        cpuReq.rd && !inPgm && cpuBlk == CPLVP_BLK_0 && pcBlk == CPLVP_BLK_0
        |=> cpuRsp.allow)
        else $error("same-block read refused");
    a_wr_inhibit: assert property (@(posedge ref_clk) disable iff (!nrst)
        cpuReq.wr && !inPgm && cpuBlk == CPLVP_BLK_0 && !wrL_reg[0]
        |=> !flashWrEn)
        else $error("inhibited table write passed");
    a_bits_no_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
        !eraseGo_next |=> (cpL_reg & ~$past(cpL_reg)) == ZERO_BYTE)
        else $error("protection bit rose without erase");
    a_cfgwp_locked: assert property (@(posedge ref_clk) disable iff (!nrst)
        !inPgm |=> $stable(wrH_reg[BIT_CFGWP]))
        else $error("config write protect changed in execution");
    a_lvp_frozen: assert property (@(posedge ref_clk) disable iff (!nrst)
        !progModeHv |=> $stable(dbg_reg[BIT_LVP]))
        else $error("lvp bit changed outside hv mode");
    a_ee_cpu_free: assert property (@(posedge ref_clk) disable iff (!nrst)
        !inPgm && cpuEeWr |=> eeAllow)
        else $error("cpu eeprom access blocked");
    a_ee_ext_block: assert property (@(posedge ref_clk) disable iff (!nrst)
        inPgm && pgmEeRd && !cpH_reg[BIT_EEPROT] |=> !eeAllow)
        else $error("protected eeprom read by programmer");
    a_id_readable: assert property (@(posedge ref_clk) disable iff (!nrst)
        inPgm && pgmReq.rd && pgmIsId |=> pgmRsp.allow)
        else $error("id location refused");
    a_ext_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        inPgm && pgmReq.rd && pgmBlk == CPLVP_BLK_0 && !cpL_reg[0]
        |=> pgmRsp.rdata == ZERO_BYTE)
        else $error("protected block read by programmer");
    a_hv_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
        masterClearHv [*6] |-> progModeHv)
        else $error("hv entry not accepted");
endmodule : cplvp_protect

/* File: verif/cplvp_prog_model.sv */
`timescale 1ns/1ps
module cplvp_prog_model (
    input  wire logic ref_clk,
    input  wire logic hvEnter,
    input  wire logic lvEnter,
    output logic      masterClearHv,
    output logic      programEntryPin
);
    initial begin
        masterClearHv   = 1'b0;
        programEntryPin = 1'b0;
    end
    // master clear stays at normal level for low-voltage entry
    always @(posedge ref_clk) begin
        masterClearHv   <= hvEnter;
        programEntryPin <= lvEnter & !hvEnter;
    end
endmodule : cplvp_prog_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench
    import cplvp_pkg::*;
;
    logic ref_clk = 1'b0, nrst = 1'b0, hvEnter = 1'b0, lvEnter = 1'b0;
    logic cpuEeRd = 1'b0, cpuEeWr = 1'b0, pgmEeRd = 1'b0, pgmEeWr = 1'b0;
    logic [ADDR_W-1:0] cpuPc = '0;
    cplvp_req_t cpuReq = '0, pgmReq = '0;
    cplvp_erase_t pgmErase = CPLVP_ER_NONE;
    cplvp_blk_t pgmEraseBlk = CPLVP_BLK_0;
    logic [7:0] flashRdata = 8'hA5;
    logic masterClearHv, programEntryPin, progModeHv, progModeLv;
    logic flashWrEn, flashWrPgm, eeAllow, eraseGo, eraseRefused;
    logic debugEnable, entryPinIsGpio;
    cplvp_rsp_t cpuRsp, pgmRsp;
    int fail_count = 0, check_count = 0;

    always #5 ref_clk = ~ref_clk;

    cplvp_prog_model u_prog (.ref_clk(ref_clk), .hvEnter(hvEnter),
        .lvEnter(lvEnter), .masterClearHv(masterClearHv),
        .programEntryPin(programEntryPin));

    cplvp_protect u_dut (.ref_clk(ref_clk), .nrst(nrst), .cpuReq(cpuReq),
        .cpuPc(cpuPc), .cpuEeRd(cpuEeRd), .cpuEeWr(cpuEeWr),
        .pgmReq(pgmReq), .pgmEeRd(pgmEeRd), .pgmEeWr(pgmEeWr),
        .pgmErase(pgmErase), .pgmEraseBlk(pgmEraseBlk),
        .masterClearHv(masterClearHv), .programEntryPin(programEntryPin),
        .flashRdata(flashRdata), .progModeHv(progModeHv),
        .progModeLv(progModeLv), .cpuRsp(cpuRsp), .pgmRsp(pgmRsp),
        .flashWrEn(flashWrEn), .flashWrPgm(flashWrPgm), .eeAllow(eeAllow),
        .eraseGo(eraseGo), .eraseRefused(eraseRefused),
        .debugEnable(debugEnable), .entryPinIsGpio(entryPinIsGpio));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one access, held for one edge; answer sampled 1 ns after that same edge
    task automatic access(input bit program_entry_pin, input bit wr,
                          input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        if (program_entry_pin) pgmReq <= '{!wr, wr, a, d};
        else cpuReq <= '{!wr, wr, a, d};
        @(posedge ref_clk);
        pgmReq <= '0;
        cpuReq <= '0;
        #1;
    endtask : access

    task automatic wait_mode(input bit lv, input logic exp);
        int n;
        n = 0;
        while ((lv ? progModeLv : progModeHv) !== exp && n < 12) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({7'h0, lv ? progModeLv : progModeHv}, {7'h0, exp});
    endtask : wait_mode

    task automatic test_reset();
        repeat (2) @(posedge ref_clk);
        #1;
        check({7'h0, entryPinIsGpio}, 8'h00);
        check({7'h0, debugEnable}, 8'h00);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_cpu();
        cpuPc <= 22'h00_0900;
        access(0, 1, CFG_RD_L, 8'hFE);
        access(0, 0, 22'h00_0300, 8'h00);
        check(cpuRsp.rdata, ZERO_BYTE);
        cpuPc <= 22'h00_0400;
        access(0, 0, 22'h00_0300, 8'h00);
        check(cpuRsp.rdata, 8'hA5);
        access(0, 1, CFG_RD_L, 8'hFF);
        access(0, 0, CFG_RD_L, 8'h00);
        check({7'h0, cpuRsp.rdata[0]}, 8'h00);
        access(0, 1, CFG_WR_L, 8'hFE);
        access(0, 1, 22'h00_0300, 8'h5A);
        check({7'h0, flashWrEn}, 8'h00);
        access(0, 1, 22'h00_0900, 8'h5A);
        check({7'h0, flashWrEn}, 8'h01);
        access(0, 1, ID_LAST, 8'h3C);
        access(0, 0, ID_LAST, 8'h00);
        check(cpuRsp.rdata, 8'h3C);
        @(posedge ref_clk);
        cpuEeWr <= 1'b1;
        @(posedge ref_clk);
        cpuEeWr <= 1'b0;
        #1;
        check({7'h0, eeAllow}, 8'h01);
        $display("test_cpu done");
    endtask : test_cpu

    task automatic test_lv();
        lvEnter <= 1'b1;
        wait_mode(1, 1'b1);
        lvEnter <= 1'b0;
        wait_mode(1, 1'b0);
        $display("test_lv done");
    endtask : test_lv

    task automatic test_hv();
        hvEnter <= 1'b1;
        wait_mode(0, 1'b1);
        access(0, 0, 22'h00_0900, 8'h00);
        check({7'h0, cpuRsp.valid}, 8'h00);
        access(1, 1, CFG_CP_L, 8'hFE);
        check({7'h0, flashWrPgm}, 8'h01);
        access(1, 0, 22'h00_0300, 8'h00);
        check(pgmRsp.rdata, ZERO_BYTE);
        access(1, 1, 22'h00_0300, 8'h77);
        check({7'h0, flashWrEn}, 8'h00);
        access(1, 0, ID_LAST, 8'h00);
        check(pgmRsp.rdata, 8'h3C);
        @(posedge ref_clk);
        pgmErase <= CPLVP_ER_ROW;
        pgmReq <= '{1'b0, 1'b0, 22'h00_0300, 8'h00};
        @(posedge ref_clk);
        pgmErase <= CPLVP_ER_BLOCK;
        pgmEraseBlk <= CPLVP_BLK_0;
        pgmReq <= '0;
        #1;
        check({7'h0, eraseRefused}, 8'h01);
        @(posedge ref_clk);
        pgmErase <= CPLVP_ER_NONE;
        #1;
        check({7'h0, eraseGo}, 8'h01);
        access(1, 0, 22'h00_0300, 8'h00);
        check(pgmRsp.rdata, 8'hA5);
        @(posedge ref_clk);
        pgmEeRd <= 1'b1;
        @(posedge ref_clk);
        pgmEeRd <= 1'b0;
        #1;
        check({7'h0, eeAllow}, 8'h01);
        $display("test_hv done");
    endtask : test_hv

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    initial begin
        #20000;
        fail_count++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        test_reset();
        test_cpu();
        test_lv();
        test_hv();
        final_report();
    end
endmodule : testbench
